// ### ccr_channel.sv
`timescale 1ns/1ns
module ccr_channel import ccr_pkg::*; #(
  parameter bit WIDE = 1'b1
) (
  input logic clk,
  input logic rst_b,
  input ccr_conv_s conv_in,
  input logic rd_upper,
  output logic [15:0] upper_word,
  output logic [15:0] lower_word
);

  logic [RESULT_W-1:0] res_q;
  logic to_q;
  logic aw_q;
  logic [LOWER_W-1:0] shadow_q;
  logic to_d;
  logic aw_d;

  // ****************************************
  // Sticky flags, set beats read clear
  // ****************************************
  assign to_d = conv_in.timeout | (to_q & ~rd_upper);
  assign aw_d = conv_in.amp | (aw_q & ~rd_upper);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      res_q <= '0;
      to_q <= 1'b0;
      aw_q <= 1'b0;
      shadow_q <= '0;
    end else begin
      to_q <= to_d;
      aw_q <= aw_d;
      if (conv_in.valid) begin
        res_q <= conv_in.data;
      end
      // Lower half frozen when the upper half is taken
      if (rd_upper) begin
        shadow_q <= res_q[LOWER_W-1:0];
      end
    end
  end

  // ****************************************
  // Word layout
  // ****************************************
  always_comb begin
    upper_word = WORD_RST;
    upper_word[TO_BIT] = to_q;
    upper_word[AW_BIT] = aw_q;
    if (WIDE) begin
      upper_word[DATA_HI:0] = res_q[RESULT_W-1:LOWER_W];
    end else begin
      upper_word[DATA_HI:0] = res_q[DATA_HI:0];
    end
  end

  assign lower_word = WIDE ? shadow_q : WORD_RST;

  // ****************************************
  // Checks
  // ****************************************
  sequence amp_seen_s;
    conv_in.amp;
  endsequence

  sequence clean_read_s;
    rd_upper && !conv_in.amp;
  endsequence

  property amp_cleared_p;
    @(posedge clk) disable iff (!rst_b) amp_seen_s ##[1:1000] clean_read_s |=> !aw_q;
  endproperty

  timeout_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    conv_in.timeout |=> upper_word[TO_BIT] ##1 (upper_word[TO_BIT] || $past(rd_upper)))
    else $error("timeout flag not set");
  timeout_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    rd_upper && !conv_in.timeout |=> !upper_word[TO_BIT])
    else $error("timeout flag not cleared by read");
  amp_clear_a: assert property (amp_cleared_p)
    else $error("amplitude flag not cleared by read");
  amp_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    rd_upper && conv_in.amp |=> upper_word[AW_BIT])
    else $error("amplitude event lost on read");
  result_coherent_a: assert property (@(posedge clk) disable iff (!rst_b)
    rd_upper && WIDE |=> lower_word == $past(res_q[LOWER_W-1:0]))
    else $error("lower half not frozen with upper read");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    conv_in.valid |=> upper_word[15:14] == 2'b00 && $stable(upper_word[15:14]))
    else $error("reserved bits not zero");
  upper_field_a: assert property (@(posedge clk) disable iff (!rst_b)
    conv_in.valid |=> upper_word[DATA_HI:0] ==
      (WIDE ? $past(conv_in.data[RESULT_W-1:LOWER_W]) : $past(conv_in.data[DATA_HI:0])))
    else $error("result field misplaced");

endmodule

// ### ccr_host_model.sv
`timescale 1ns/1ns
// ****************************************
// Two-wire bus host model
// ****************************************
module ccr_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  localparam int T = 11;
  logic [6:0] dev = 7'h2A;
  logic nak = 1'b0;
  logic [15:0] rd_q [4];

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Third of a bit: both bus phases stay above ten system clocks
  task automatic tick();
    repeat (T) @(posedge clk);
    #1;
  endtask

  task automatic put(input logic b);
    sda_low = ~b;
    tick();
    scl = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask

  // Line released, so a silent device reads as pull-up high
  task automatic get(output logic b);
    sda_low = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    b = sda;
    scl = 1'b0;
    tick();
  endtask

  task automatic start();
    sda_low = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask

  task automatic stop();
    sda_low = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b0;
    tick();
  endtask

  task automatic byte_out(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put(d[i]);
    end
    get(a);
    if (a) begin
      nak = 1'b1;
    end
  endtask

  task automatic byte_in(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) begin
      get(d[i]);
    end
    put(last);
  endtask

  task automatic write(input logic [7:0] ptr, input logic [15:0] w);
    start();
    byte_out({dev, 1'b0});
    byte_out(ptr);
    byte_out(w[15:8]);
    byte_out(w[7:0]);
    stop();
  endtask

  // Words come in rising pointer order, so an upper word precedes its lower
  task automatic read(input logic [7:0] ptr, input int n);
    start();
    byte_out({dev, 1'b0});
    byte_out(ptr);
    start();
    byte_out({dev, 1'b1});
    for (int k = 0; k < n; k++) begin
      byte_in(rd_q[k][15:8], 1'b0);
      byte_in(rd_q[k][7:0], k == n - 1);
    end
    stop();
  endtask
endmodule

// ### ccr_pin_filter.sv
`timescale 1ns/1ns
module ccr_pin_filter import ccr_pkg::*; #(
  parameter logic IDLE_LVL = 1'b1
) (
  input logic clk,
  input logic rst_b,
  input logic pin_in,
  output logic level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  // ****************************************
  // Three-stage sampler with agreement filter
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= IDLE_LVL;
      s2_q <= IDLE_LVL;
      s3_q <= IDLE_LVL;
      lvl_q <= IDLE_LVL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign level = lvl_q;

endmodule

// ### ccr_pkg.sv
package ccr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int NCH = 3;
  localparam logic [7:0] OFF_UPPER [NCH] = '{8'h02, 8'h04, 8'h06};
  localparam logic [7:0] OFF_LOWER [NCH] = '{8'h03, 8'h05, 8'h07};
  localparam logic [7:0] OFF_INTERVAL [NCH] = '{8'h08, 8'h09, 8'h0A};

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int RESULT_W = 28;
  localparam int LOWER_W = 16;
  localparam int DATA_HI = 11;
  localparam int TO_BIT = 13;
  localparam int AW_BIT = 12;
  localparam logic [15:0] INTERVAL_RST = 16'h0080;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ****************************************
  // Conversion engine carrier
  // ****************************************
  typedef struct packed {
    logic valid;
    logic [RESULT_W-1:0] data;
    logic timeout;
    logic amp;
  } ccr_conv_s;

  // ****************************************
  // Serial slave states
  // ****************************************
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_ACK_A = 9'h004,
    ST_PTR   = 9'h008,
    ST_ACK_P = 9'h010,
    ST_WDAT  = 9'h020,
    ST_ACK_W = 9'h040,
    ST_RDAT  = 9'h080,
    ST_ACK_R = 9'h100
  } ccr_state_e;

endpackage

// ### ccr_result_regs.sv
`timescale 1ns/1ns
// Operation
// - Channel 1 timeout sets upper bit 13; reading the register clears it.
// - Channel 1 amplitude warning sets upper bit 12; cleared on read.
// - Channel 2 timeout sets upper bit 13; cleared by reading.
// - Channel 2 amplitude warning sets upper bit 12; cleared by reading.
// - Channel 3 timeout sets upper bit 13; cleared by reading.
// - Channel 3 amplitude warning sets upper bit 12; cleared by reading.
// - Narrow variant shows channel 1 result bits 11:0 in bits 11:0, read only.
// - Narrow variant shows channel 2 result bits 11:0 in bits 11:0, read only.
// - Wide variant: result 27:16 in upper 11:0, 15:0 in lower word.
// - Channel 0 interval is 16-bit read/write; host avoids values to 0x00FF.
// - Channel 0 interval resets to 0x0080.
// - Channel 1 interval behaves as channel 0, same reset value.
module ccr_result_regs import ccr_pkg::*; #(
  parameter bit WIDE = 1'b1,
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input logic clk,
  input logic rst_b,
  input logic scl_in,
  input logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input ccr_conv_s ch_conv [NCH],
  output logic [15:0] ch0_interval_count,
  output logic [15:0] ch1_interval_count,
  output logic [15:0] ch2_interval_count
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_q;
  logic rst_sync_b;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_b <= rst_meta_q;
    end
  end

  // ****************************************
  // Pin conditioning and bus events
  // ****************************************
  logic scl_lvl;
  logic sda_lvl;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  ccr_pin_filter #(.IDLE_LVL(1'b1)) u_scl_filt (
    .clk(clk),
    .rst_b(rst_sync_b),
    .pin_in(scl_in),
    .level(scl_lvl)
  );

  ccr_pin_filter #(.IDLE_LVL(1'b1)) u_sda_filt (
    .clk(clk),
    .rst_b(rst_sync_b),
    .pin_in(sda_in),
    .level(sda_lvl)
  );

  assign scl_rise = scl_lvl & ~scl_prev_q;
  assign scl_fall = ~scl_lvl & scl_prev_q;
  assign start_det = scl_lvl & scl_prev_q & sda_prev_q & ~sda_lvl;
  assign stop_det = scl_lvl & scl_prev_q & ~sda_prev_q & sda_lvl;

  // ****************************************
  // Slave state
  // ****************************************
  ccr_state_e state_q;
  ccr_state_e state_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic [7:0] wmsb_q;
  logic [7:0] wmsb_d;
  logic [15:0] rword_q;
  logic [15:0] rword_d;
  logic rd_mode_q;
  logic rd_mode_d;
  logic hi_q;
  logic hi_d;
  logic mack_q;
  logic mack_d;
  logic oe_q;
  logic oe_d;
  logic sda_out_q;
  logic wr_word;
  logic load_word;
  logic rx_state;
  logic rx_done;
  logic addr_match;
  logic [15:0] rd_word;
  logic [15:0] interval_q [NCH];
  logic [15:0] chan_upper [NCH];
  logic [15:0] chan_lower [NCH];
  logic [NCH-1:0] rd_upper;

  assign rx_state = (state_q == ST_ADDR) | (state_q == ST_PTR) | (state_q == ST_WDAT);
  assign rx_done = scl_fall & (cnt_q == BITS_PER_BYTE);
  assign addr_match = shift_q[7:1] == DEV_ADDR;
  // A word is fetched when a read byte pair begins
  assign load_word = scl_fall & (((state_q == ST_ACK_A) & rd_mode_q) |
                                 ((state_q == ST_ACK_R) & ~mack_q & hi_q));

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    cnt_d = cnt_q;
    ptr_d = ptr_q;
    wmsb_d = wmsb_q;
    rword_d = rword_q;
    rd_mode_d = rd_mode_q;
    hi_d = hi_q;
    mack_d = mack_q;
    oe_d = oe_q;
    wr_word = 1'b0;
    if (start_det) begin
      state_d = ST_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop_det) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
    end else begin
      if (rx_state && scl_rise) begin
        shift_d = {shift_q[6:0], sda_lvl};
        cnt_d = cnt_q + 4'h1;
      end
      unique case (state_q)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (rx_done) begin
            cnt_d = 4'h0;
            if (addr_match) begin
              rd_mode_d = shift_q[0];
              oe_d = 1'b1;
              state_d = ST_ACK_A;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_PTR: begin
          if (rx_done) begin
            cnt_d = 4'h0;
            ptr_d = shift_q;
            hi_d = 1'b1;
            oe_d = 1'b1;
            state_d = ST_ACK_P;
          end
        end
        ST_WDAT: begin
          if (rx_done) begin
            cnt_d = 4'h0;
            oe_d = 1'b1;
            state_d = ST_ACK_W;
            if (hi_q) begin
              wmsb_d = shift_q;
              hi_d = 1'b0;
            end else begin
              wr_word = 1'b1;
              hi_d = 1'b1;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        ST_ACK_P, ST_ACK_W: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            state_d = ST_WDAT;
          end
        end
        ST_ACK_A: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            oe_d = 1'b0;
            state_d = ST_PTR;
            if (rd_mode_q) begin
              rword_d = rd_word;
              shift_d = rd_word[15:8];
              oe_d = ~rd_word[15];
              cnt_d = 4'h1;
              hi_d = 1'b0;
              state_d = ST_RDAT;
            end
          end
        end
        ST_RDAT: begin
          if (scl_fall) begin
            if (cnt_q == BITS_PER_BYTE) begin
              oe_d = 1'b0;
              cnt_d = 4'h0;
              state_d = ST_ACK_R;
              if (hi_q) begin
                ptr_d = ptr_q + 8'h01;
              end
            end else begin
              oe_d = ~shift_q[6];
              shift_d = {shift_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ST_ACK_R: begin
          if (scl_rise) begin
            mack_d = sda_lvl;
          end else if (scl_fall) begin
            cnt_d = 4'h1;
            state_d = ST_RDAT;
            if (mack_q) begin
              state_d = ST_IDLE;
            end else if (!hi_q) begin
              shift_d = rword_q[7:0];
              oe_d = ~rword_q[7];
              hi_d = 1'b1;
            end else begin
              rword_d = rd_word;
              shift_d = rd_word[15:8];
              oe_d = ~rd_word[15];
              hi_d = 1'b0;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00;
      cnt_q <= 4'h0;
      ptr_q <= 8'h00;
      wmsb_q <= 8'h00;
      rword_q <= WORD_RST;
      rd_mode_q <= 1'b0;
      hi_q <= 1'b1;
      mack_q <= 1'b1;
      oe_q <= 1'b0;
      sda_out_q <= 1'b0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      ptr_q <= ptr_d;
      wmsb_q <= wmsb_d;
      rword_q <= rword_d;
      rd_mode_q <= rd_mode_d;
      hi_q <= hi_d;
      mack_q <= mack_d;
      oe_q <= oe_d;
      sda_out_q <= 1'b0;
      scl_prev_q <= scl_lvl;
      sda_prev_q <= sda_lvl;
    end
  end

  // ****************************************
  // Channels and interval counts
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      // Reading an upper word clears its flags
      assign rd_upper[gi] = load_word & (ptr_q == OFF_UPPER[gi]);

      ccr_channel #(.WIDE(WIDE)) u_ch (
        .clk(clk),
        .rst_b(rst_sync_b),
        .conv_in(ch_conv[gi]),
        .rd_upper(rd_upper[gi]),
        .upper_word(chan_upper[gi]),
        .lower_word(chan_lower[gi])
      );

      always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          interval_q[gi] <= INTERVAL_RST;
        end else if (wr_word && ptr_q == OFF_INTERVAL[gi]) begin
          interval_q[gi] <= {wmsb_q, shift_q};
        end
      end
    end
  endgenerate

  // Unmapped pointers read as zero; result words are read only
  always_comb begin
    rd_word = WORD_RST;
    for (int i = 0; i < NCH; i++) begin
      if (ptr_q == OFF_UPPER[i]) begin
        rd_word = chan_upper[i];
      end
      if (ptr_q == OFF_LOWER[i]) begin
        rd_word = chan_lower[i];
      end
      if (ptr_q == OFF_INTERVAL[i]) begin
        rd_word = interval_q[i];
      end
    end
  end

  assign sda_out = sda_out_q;
  assign sda_oe = oe_q;
  assign ch0_interval_count = interval_q[0];
  assign ch1_interval_count = interval_q[1];
  assign ch2_interval_count = interval_q[2];

  // ****************************************
  // Checks
  // ****************************************
  interval_write_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    wr_word && ptr_q == OFF_INTERVAL[0] |=> ch0_interval_count == $past({wmsb_q, shift_q}))
    else $error("interval write lost");
  interval_reset_a: assert property (@(posedge clk)
    $rose(rst_sync_b) |-> ch0_interval_count == INTERVAL_RST &&
      ch1_interval_count == INTERVAL_RST && ch2_interval_count == INTERVAL_RST)
    else $error("interval reset value wrong");
  addr_ack_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    state_q == ST_ADDR && rx_done && addr_match && !start_det && !stop_det
      |=> sda_oe && state_q == ST_ACK_A)
    else $error("address not acknowledged");
  upper_read_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    |rd_upper && !start_det && !stop_det |=> rword_q[15:14] == 2'b00)
    else $error("reserved bits driven");

endmodule

// ### ccr_result_regs_tb.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    n_tests++; \
    if ((got) !== (ex)) begin \
      err_total++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
  end

module ccr_result_regs_tb import ccr_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  ccr_conv_s conv [NCH] = '{default: '0};
  wire logic scl;
  wire logic sda_low;
  wire logic oe_w;
  wire logic oe_n;
  wire logic sdo;
  wire logic sda = ~(sda_low | oe_w | oe_n);
  logic [15:0] cnt [NCH];
  logic [15:0] wv [NCH] = '{16'h0100, 16'hFFFF, 16'hA5C3};
  logic [27:0] dv [NCH] = '{28'hA5C3E17, 28'h3B6D094, 28'h0F1E2D3};
  logic [27:0] d;
  logic to;
  logic aw;
  int err_total = 0;
  int n_tests = 0;

  initial begin
    forever #50 clk = ~clk;
  end

  ccr_result_regs #(.WIDE(1'b1), .DEV_ADDR(7'h2A)) u_dut (.clk(clk), .rst_b(rst_b),
    .scl_in(scl), .sda_in(sda), .sda_out(sdo), .sda_oe(oe_w), .ch_conv(conv),
    .ch0_interval_count(cnt[0]), .ch1_interval_count(cnt[1]), .ch2_interval_count(cnt[2]));
  ccr_result_regs #(.WIDE(1'b0), .DEV_ADDR(7'h2B)) u_narrow (.clk(clk), .rst_b(rst_b),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(oe_n), .ch_conv(conv),
    .ch0_interval_count(), .ch1_interval_count(), .ch2_interval_count());
  ccr_host_model u_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic pulse(input int c, input logic [27:0] v, input logic t, input logic a);
    @(posedge clk);
    #1;
    conv[c] = '{valid: 1'b1, data: v, timeout: t, amp: a};
    @(posedge clk);
    #1;
    conv[c] = '0;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    close_out();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (20) @(posedge clk);
    `CHK("ch0 count", 16'h0080, cnt[0])
    `CHK("ch1 count", 16'h0080, cnt[1])
    u_host.read(8'h08, 2);
    `CHK("ch0 interval", 16'h0080, u_host.rd_q[0])
    `CHK("ch1 interval", 16'h0080, u_host.rd_q[1])
    for (int i = 0; i < NCH; i++) begin
      u_host.write(OFF_INTERVAL[i], wv[i]);
      `CHK("count port", wv[i], cnt[i])
    end
    u_host.read(8'h08, 3);
    for (int i = 0; i < NCH; i++) begin
      `CHK("interval read", wv[i], u_host.rd_q[i])
    end
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < NCH; c++) begin
        d = dv[c] + 28'(r);
        to = (r == 0) || (c == 2);
        aw = (r == 1) || (c == 2);
        pulse(c, d, to, aw);
        u_host.dev = 7'h2B;
        u_host.read(OFF_UPPER[c], 1);
        `CHK("narrow upper", {2'b00, to, aw, d[11:0]}, u_host.rd_q[0])
        u_host.dev = 7'h2A;
        u_host.read(OFF_UPPER[c], 2);
        `CHK("upper", {2'b00, to, aw, d[27:16]}, u_host.rd_q[0])
        `CHK("lower", d[15:0], u_host.rd_q[1])
        u_host.read(OFF_UPPER[c], 1);
        `CHK("flags cleared", {4'h0, d[27:16]}, u_host.rd_q[0])
      end
    end
    // Lower half stays with its upper even after a newer result lands
    pulse(0, 28'h7E81A24, 1'b0, 1'b0);
    u_host.read(8'h02, 1);
    pulse(0, 28'h1234567, 1'b0, 1'b0);
    u_host.read(8'h03, 1);
    `CHK("frozen lower", 16'h1A24, u_host.rd_q[0])
    u_host.write(8'h02, 16'h3FFF);
    u_host.write(8'h03, 16'h0000);
    u_host.read(8'h02, 2);
    `CHK("upper read only", 16'h0123, u_host.rd_q[0])
    `CHK("lower read only", 16'h4567, u_host.rd_q[1])
    u_host.read(8'h0C, 1);
    `CHK("unmapped", 16'h0000, u_host.rd_q[0])
    `CHK("no refusal", 1'b0, u_host.nak)
    `CHK("data out level", 1'b0, sdo)
    // Warning held high across its own fetch stays set
    conv[1].amp = 1'b1;
    u_host.read(OFF_UPPER[1], 1);
    conv[1].amp = 1'b0;
    `CHK("held warning", {4'h1, dv[1][27:16]}, u_host.rd_q[0])
    u_host.read(OFF_UPPER[1], 1);
    `CHK("warning kept", {4'h1, dv[1][27:16]}, u_host.rd_q[0])
    u_host.read(OFF_UPPER[1], 1);
    `CHK("warning gone", {4'h0, dv[1][27:16]}, u_host.rd_q[0])
    @(posedge clk);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge clk);
    `CHK("ch0 count reset", 16'h0080, cnt[0])
    `CHK("ch1 count reset", 16'h0080, cnt[1])
    #1 rst_b = 1'b1;
    repeat (20) @(posedge clk);
    u_host.read(8'h08, 3);
    for (int i = 0; i < NCH; i++) begin
      `CHK("interval after reset", 16'h0080, u_host.rd_q[i])
    end
    close_out();
  end
endmodule
